// >>> design/bopd_regs.svh
// opcode patterns, field positions and register map constants for the byte-op decoder
`ifndef BOPD_REGS_SVH
`define BOPD_REGS_SVH
// instruction word fields
`define BOPD_OP6_HI        15
`define BOPD_OP6_LO        10
`define BOPD_OP7_LO        9
`define BOPD_NIB_LO        12
`define BOPD_D_BIT         9
`define BOPD_A_BIT         8
// opcode patterns (top six bits with d,a; top seven bits with a only)
`define BOPD_OP_ADDC       6'h08
`define BOPD_OP_DECSZ      6'h0B
`define BOPD_OP_DECSNZ     6'h13
`define BOPD_OP_INCSZ      6'h0F
`define BOPD_OP_INCSNZ     6'h12
`define BOPD_OP_IOR        6'h04
`define BOPD_OP_CPEQ       7'h31
`define BOPD_OP_CPGT       7'h32
`define BOPD_OP_CPLT       7'h30
`define BOPD_NIB_COPY1     4'hC
`define BOPD_NIB_COPY2     4'hF
// flag enable bit positions: c, dc, z, ov, n
`define BOPD_FLG_C         0
`define BOPD_FLG_DC        1
`define BOPD_FLG_Z         2
`define BOPD_FLG_OV        3
`define BOPD_FLG_N         4
`define BOPD_FLG_ALL       5'h1F
`define BOPD_FLG_ZN        5'h14
`define BOPD_FLG_NONE      5'h00
// register map (byte addresses)
`define BOPD_ADDR_CTRL     12'h000
`define BOPD_ADDR_INSTR    12'h004
`define BOPD_ADDR_OPER     12'h008
`define BOPD_ADDR_STATUS   12'h00C
`define BOPD_ADDR_COPY     12'h010
`define BOPD_CTRL_RST      32'h0000_0001
`define BOPD_ZERO32        32'h0000_0000
`endif

// >>> design/bopd_pkg.sv
// types shared by the byte-op decoder files
package bopd_pkg;
  // alu operation selects
  typedef enum logic [2:0] {
    BOPD_ALU_NOP  = 3'h0,
    BOPD_ALU_ADDC = 3'h1,
    BOPD_ALU_DEC  = 3'h2,
    BOPD_ALU_INC  = 3'h3,
    BOPD_ALU_OR   = 3'h4,
    BOPD_ALU_CMP  = 3'h5,
    BOPD_ALU_MOVE = 3'h6
  } bopd_alu_t;
  // skip condition kinds
  typedef enum logic [2:0] {
    BOPD_SK_NONE = 3'h0,
    BOPD_SK_EQ   = 3'h1,
    BOPD_SK_GT   = 3'h2,
    BOPD_SK_LT   = 3'h3,
    BOPD_SK_Z    = 3'h4,
    BOPD_SK_NZ   = 3'h5
  } bopd_skip_t;
  // sequencing states
  typedef enum logic [2:0] {
    BOPD_ST_RUN   = 3'b001,
    BOPD_ST_SKIP  = 3'b010,
    BOPD_ST_COPY2 = 3'b100
  } bopd_state_t;
endpackage

// >>> design/bopd_decode.sv
// combinational opcode decoder for one 16-bit instruction word
`timescale 1ns/1ps
`include "bopd_regs.svh"
module bopd_decode (
  // instruction word
  input  wire logic [15:0]         instr,
  // decoded controls
  output bopd_pkg::bopd_alu_t      alu_op,
  output bopd_pkg::bopd_skip_t     skip_kind,
  output logic      [4:0]          flag_en,
  output logic                     dest_file,
  output logic                     bank_sel,
  output logic                     copy_first,
  output logic                     copy_second
);
  logic [5:0] op6;  // top six opcode bits
  logic [6:0] op7;  // top seven opcode bits
  logic [3:0] nib;  // top nibble
  assign op6 = instr[`BOPD_OP6_HI:`BOPD_OP6_LO];
  assign op7 = instr[`BOPD_OP6_HI:`BOPD_OP7_LO];
  assign nib = instr[`BOPD_OP6_HI:`BOPD_NIB_LO];
  assign bank_sel    = instr[`BOPD_A_BIT];
  assign copy_first  = (nib == `BOPD_NIB_COPY1);
  assign copy_second = (nib == `BOPD_NIB_COPY2);
  // opcode table
  always_comb begin
    alu_op    = bopd_pkg::BOPD_ALU_NOP;
    skip_kind = bopd_pkg::BOPD_SK_NONE;
    flag_en   = `BOPD_FLG_NONE;
    dest_file = 1'b0;
    if (op6 == `BOPD_OP_ADDC) begin
      alu_op    = bopd_pkg::BOPD_ALU_ADDC;
      flag_en   = `BOPD_FLG_ALL;
      dest_file = instr[`BOPD_D_BIT];
    end else if (op6 == `BOPD_OP_DECSZ) begin
      alu_op    = bopd_pkg::BOPD_ALU_DEC;
      skip_kind = bopd_pkg::BOPD_SK_Z;
      dest_file = instr[`BOPD_D_BIT];
    end else if (op6 == `BOPD_OP_DECSNZ) begin
      alu_op    = bopd_pkg::BOPD_ALU_DEC;
      skip_kind = bopd_pkg::BOPD_SK_NZ;
      dest_file = instr[`BOPD_D_BIT];
    end else if (op6 == `BOPD_OP_INCSZ) begin
      alu_op    = bopd_pkg::BOPD_ALU_INC;
      skip_kind = bopd_pkg::BOPD_SK_Z;
      dest_file = instr[`BOPD_D_BIT];
    end else if (op6 == `BOPD_OP_INCSNZ) begin
      alu_op    = bopd_pkg::BOPD_ALU_INC;
      skip_kind = bopd_pkg::BOPD_SK_NZ;
      dest_file = instr[`BOPD_D_BIT];
    end else if (op6 == `BOPD_OP_IOR) begin
      alu_op    = bopd_pkg::BOPD_ALU_OR;
      flag_en   = `BOPD_FLG_ZN;
      dest_file = instr[`BOPD_D_BIT];
    end else if (op7 == `BOPD_OP_CPEQ) begin
      alu_op    = bopd_pkg::BOPD_ALU_CMP;
      skip_kind = bopd_pkg::BOPD_SK_EQ;
    end else if (op7 == `BOPD_OP_CPGT) begin
      alu_op    = bopd_pkg::BOPD_ALU_CMP;
      skip_kind = bopd_pkg::BOPD_SK_GT;
    end else if (op7 == `BOPD_OP_CPLT) begin
      alu_op    = bopd_pkg::BOPD_ALU_CMP;
      skip_kind = bopd_pkg::BOPD_SK_LT;
    end else if (copy_first) begin
      alu_op    = bopd_pkg::BOPD_ALU_MOVE;
      dest_file = 1'b1;
    end
  end
endmodule

// >>> design/bopd_top.sv
// byte-op instruction decoder with an ahb-lite register front end
`timescale 1ns/1ps
`include "bopd_regs.svh"
module bopd_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // decoded controls to the datapath
  output logic      [2:0]  alu_sel,
  output logic      [4:0]  flag_update,
  output logic             dest_to_file,
  output logic             bank_select,
  output logic             skip_request,
  output logic             exec_nop
);
  // decoder outputs for the word being issued
  bopd_pkg::bopd_alu_t  dec_alu;
  bopd_pkg::bopd_skip_t dec_skip;
  logic [4:0]  dec_flags;
  logic        dec_dest;
  logic        dec_bank;
  logic        dec_copy1;
  logic        dec_copy2;
  // software-visible state and the internal issue pulse
  logic [15:0] instr;        // word written for issue
  logic [7:0]  acc_val;      // working_accumulator operand
  logic [7:0]  file_val;     // addressed file byte operand
  logic        carry_in;     // carry for add-with-carry
  logic [11:0] copy_src;     // file_to_file_copy source address
  logic [11:0] copy_dst;     // file_to_file_copy destination
  logic        copy_done;    // copy pair completed
  logic [7:0]  result;       // alu result byte
  logic [4:0]  flags;        // c dc z ov n as computed
  logic        issue;        // one-cycle pulse: a word was written
  bopd_pkg::bopd_state_t state;
  // ahb address phase capture
  logic        ph_wr;
  logic        ph_rd;
  logic [11:0] ph_addr;
  logic        take;
  assign take = hsel & hready & htrans[1];

  bopd_decode u_dec (
    .instr       (instr),
    .alu_op      (dec_alu),
    .skip_kind   (dec_skip),
    .flag_en     (dec_flags),
    .dest_file   (dec_dest),
    .bank_sel    (dec_bank),
    .copy_first  (dec_copy1),
    .copy_second (dec_copy2)
  );

  // address phase register; slave always ready, zero wait
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_wr   <= 1'b0;
      ph_rd   <= 1'b0;
      ph_addr <= 12'h000;
    end else begin
      ph_wr   <= take & hwrite;
      ph_rd   <= take & ~hwrite;
      ph_addr <= haddr;
    end
  end

  // answer signals never stall and are always okay
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // write side: operands, then the instruction word which issues
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      instr    <= 16'h0000;
      acc_val  <= 8'h00;
      file_val <= 8'h00;
      carry_in <= 1'b0;
      issue    <= 1'b0;
    end else begin
      issue <= 1'b0;
      if (ph_wr) begin
        if (ph_addr == `BOPD_ADDR_INSTR) begin
          instr <= hwdata[15:0];
          issue <= 1'b1;
        end else if (ph_addr == `BOPD_ADDR_OPER) begin
          acc_val  <= hwdata[7:0];
          file_val <= hwdata[15:8];
          carry_in <= hwdata[16];
        end
      end
    end
  end

  // alu model for skip tests and flags
  always_comb begin
    logic [8:0] sum;
    logic [4:0] lo;
    sum    = 9'h000;
    lo     = 5'h00;
    result = 8'h00;
    flags  = 5'h00;
    unique case (dec_alu)
      bopd_pkg::BOPD_ALU_ADDC: begin
        sum    = {1'b0, acc_val} + {1'b0, file_val} + {8'h00, carry_in};
        lo     = {1'b0, acc_val[3:0]} + {1'b0, file_val[3:0]} + {4'h0, carry_in};
        result = sum[7:0];
        flags[`BOPD_FLG_C]  = sum[8];
        flags[`BOPD_FLG_DC] = lo[4];
        flags[`BOPD_FLG_OV] = (acc_val[7] == file_val[7]) & (sum[7] != acc_val[7]);
      end
      bopd_pkg::BOPD_ALU_DEC:  result = file_val - 8'h01;
      bopd_pkg::BOPD_ALU_INC:  result = file_val + 8'h01;
      bopd_pkg::BOPD_ALU_OR:   result = acc_val | file_val;
      bopd_pkg::BOPD_ALU_MOVE: result = file_val;
      default:                 result = 8'h00;
    endcase
    flags[`BOPD_FLG_Z] = (result == 8'h00);
    flags[`BOPD_FLG_N] = result[7];
  end

  // skip condition evaluation
  logic skip_true;
  always_comb begin
    unique case (dec_skip)
      bopd_pkg::BOPD_SK_EQ: skip_true = (file_val == acc_val);
      bopd_pkg::BOPD_SK_GT: skip_true = (file_val > acc_val);
      bopd_pkg::BOPD_SK_LT: skip_true = (file_val < acc_val);
      bopd_pkg::BOPD_SK_Z:  skip_true = (result == 8'h00);
      bopd_pkg::BOPD_SK_NZ: skip_true = (result != 8'h00);
      default:              skip_true = 1'b0;
    endcase
  end

  // sequencer: skip no-op cycle and copy second word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= bopd_pkg::BOPD_ST_RUN;
    end else if (issue) begin
      unique case (state)
        bopd_pkg::BOPD_ST_RUN: begin
          if (dec_copy1) begin
            state <= bopd_pkg::BOPD_ST_COPY2;
          end else if (skip_true) begin
            state <= bopd_pkg::BOPD_ST_SKIP;
          end
        end
        bopd_pkg::BOPD_ST_SKIP:  state <= bopd_pkg::BOPD_ST_RUN;
        bopd_pkg::BOPD_ST_COPY2: state <= bopd_pkg::BOPD_ST_RUN;
      endcase
    end
  end

  // copy addresses: source from first word, destination from second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      copy_src  <= 12'h000;
      copy_dst  <= 12'h000;
      copy_done <= 1'b0;
    end else if (issue) begin
      if (state == bopd_pkg::BOPD_ST_RUN && dec_copy1) begin
        copy_src  <= instr[11:0];
        copy_done <= 1'b0;
      end else if (state == bopd_pkg::BOPD_ST_COPY2 && dec_copy2) begin
        copy_dst  <= instr[11:0];
        copy_done <= 1'b1;
      end
    end
  end

  // control outputs, updated per issued word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alu_sel      <= 3'h0;
      flag_update  <= `BOPD_FLG_NONE;
      dest_to_file <= 1'b0;
      bank_select  <= 1'b0;
      skip_request <= 1'b0;
      exec_nop     <= 1'b0;
    end else if (issue) begin
      if (state != bopd_pkg::BOPD_ST_RUN || dec_copy2) begin
        // skipped slot, copy second word, or lone second word: no-op
        alu_sel      <= bopd_pkg::BOPD_ALU_NOP;
        flag_update  <= `BOPD_FLG_NONE;
        dest_to_file <= 1'b0;
        bank_select  <= 1'b0;
        skip_request <= 1'b0;
        exec_nop     <= 1'b1;
      end else begin
        alu_sel      <= dec_alu;
        flag_update  <= dec_flags;
        dest_to_file <= dec_dest;
        bank_select  <= dec_bank;
        skip_request <= skip_true & ~dec_copy1;
        exec_nop     <= (dec_alu == bopd_pkg::BOPD_ALU_NOP);
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= `BOPD_ZERO32;
    end else if (take & ~hwrite) begin
      unique case (haddr)
        `BOPD_ADDR_CTRL:   hrdata <= `BOPD_CTRL_RST;
        `BOPD_ADDR_INSTR:  hrdata <= {16'h0000, instr};
        `BOPD_ADDR_OPER:   hrdata <= {15'h0000, carry_in, file_val, acc_val};
        `BOPD_ADDR_STATUS: hrdata <= {8'h00, state, flags, result, alu_sel, flag_update};
        `BOPD_ADDR_COPY:   hrdata <= {7'h00, copy_done, copy_dst, copy_src};
        default:           hrdata <= `BOPD_ZERO32;
      endcase
    end
  end
endmodule

// >>> tb/bopd_props.sv
// concurrent checks on the byte-op decoder ports
`timescale 1ns/1ps
module bopd_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // bus
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic        hwrite,
  input wire logic [1:0]  htrans,
  input wire logic [11:0] haddr,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // controls
  input wire logic [2:0]  alu_sel,
  input wire logic [4:0]  flag_update,
  input wire logic        dest_to_file,
  input wire logic        bank_select,
  input wire logic        skip_request,
  input wire logic        exec_nop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic        iss1; // instruction write in its data phase
  logic        iss2; // controls change at the next edge
  logic [15:0] word; // word being issued
  // follow an instruction write to its issue edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      iss1 <= 1'h0;
      iss2 <= 1'h0;
      word <= 16'h0000;
    end else begin
      iss1 <= hsel & hready & htrans[1] & hwrite & (haddr == 12'h004);
      iss2 <= iss1;
      if (iss1) word <= hwdata[15:0];
    end
  end
  // issue with no skip or copy pending, so the opcode alone decides
  sequence s_plain;
    iss2 && !skip_request && alu_sel != 3'h6;
  endsequence
  sequence s_rd_ctrl;
    hsel && hready && htrans[1] && !hwrite && haddr == 12'h000;
  endsequence
  chk_addc_flags: assert property (
    s_plain ##0 word[15:10] == 6'h08 |=> alu_sel == 3'h1 && flag_update == 5'h1F
    && dest_to_file == $past(word[9]) && bank_select == $past(word[8])) else $error("addc controls wrong");
  chk_cmp_quiet: assert property (
    s_plain ##0 word[15:11] == 5'h0C && word[10:9] != 2'h3 |=> alu_sel == 3'h5 && flag_update == 5'h00)
    else $error("compare controls wrong");
  chk_dec_quiet: assert property (
    s_plain ##0 (word[15:10] == 6'h0B || word[15:10] == 6'h13) |=> alu_sel == 3'h2 && flag_update == 5'h00)
    else $error("decrement controls wrong");
  chk_inc_quiet: assert property (
    s_plain ##0 (word[15:10] == 6'h0F || word[15:10] == 6'h12) |=> alu_sel == 3'h3 && flag_update == 5'h00)
    else $error("increment controls wrong");
  chk_or_flags: assert property (
    s_plain ##0 word[15:10] == 6'h04 |=> alu_sel == 3'h4 && flag_update == 5'h14) else $error("or controls wrong");
  chk_skip_nop: assert property (
    iss2 && skip_request |=> exec_nop && alu_sel == 3'h0 && !skip_request) else $error("skipped slot not a no-op");
  chk_copy_second: assert property (
    iss2 && alu_sel == 3'h6 |=> exec_nop && flag_update == 5'h00) else $error("copy second word not a no-op");
  chk_lone_second: assert property (
    s_plain ##0 word[15:12] == 4'hF |=> exec_nop) else $error("lone second word not a no-op");
  chk_ctrl_read: assert property (
    s_rd_ctrl |=> hrdata == 32'h0000_0001) else $error("control read wrong");
endmodule
bind bopd_top bopd_props u_props (.clk(clk), .rstn(rstn), .hsel(hsel), .hready(hready), .hwrite(hwrite),
  .htrans(htrans), .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata), .alu_sel(alu_sel),
  .flag_update(flag_update), .dest_to_file(dest_to_file), .bank_select(bank_select),
  .skip_request(skip_request), .exec_nop(exec_nop));

// >>> tb/bopd_fetch.sv
// fetch-side bus master that hands words and operands to the decoder
`timescale 1ns/1ps
module bopd_fetch (
  // clock and answer
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // request
  output logic             hsel,
  output logic [11:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // idle bus at time zero; whole words only
  initial begin
    hsel = 1'h1;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // call just after an edge; each phase is held until hready is seen
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= 1'h1;
    htrans <= 2'h2;
    do @(posedge clk); while (!hready);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (!hready);
  endtask
  // data line is scrambled in a read so stale write data never looks valid
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    haddr <= a;
    hwrite <= 1'h0;
    htrans <= 2'h2;
    do @(posedge clk); while (!hready);
    htrans <= 2'h0;
    hwdata <= ~hwdata;
    do @(posedge clk); while (!hready);
    d = hrdata;
  endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the byte-op decoder
`timescale 1ns/1ps
module tb_top;
  logic        clk, rstn, hsel, hwrite, hready, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize, alu_sel;
  logic [11:0] haddr;
  logic [31:0] hwdata, hrdata, rdv, cp;
  logic [4:0]  flag_update;
  logic        dest_to_file, bank_select, skip_request, exec_nop;
  logic [7:0]  acc, fb;
  logic [8:0]  ex;    // {skip, alu select, flag enables}
  logic [15:0] w;
  int          k;
  int          error_cnt = 0;
  int          total_checks = 0;
  // opcode patterns with d, a and file address cleared
  logic [15:0] base [9] = '{16'h2000, 16'h6200, 16'h6400, 16'h6000, 16'h2C00, 16'h4C00, 16'h3C00,
                            16'h4800, 16'h1000};
  bopd_top DUT (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .alu_sel(alu_sel), .flag_update(flag_update), .dest_to_file(dest_to_file), .bank_select(bank_select),
    .skip_request(skip_request), .exec_nop(exec_nop));
  bopd_fetch fetch (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // 10 MHz clock
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // expected controls per opcode row; dec/inc skip on the new value
  function automatic logic [8:0] expect_of(int k, logic [7:0] a, logic [7:0] f);
    logic [7:0] r;
    r = (k < 6) ? f - 8'h01 : f + 8'h01;
    case (k)
      0: return 9'h03F;
      1: return {f == a, 8'hA0};
      2: return {f > a, 8'hA0};
      3: return {f < a, 8'hA0};
      4: return {r == 8'h00, 8'h40};
      5: return {r != 8'h00, 8'h40};
      6: return {r == 8'h00, 8'h60};
      7: return {r != 8'h00, 8'h60};
      default: return 9'h094;
    endcase
  endfunction
  // operands first, then the word; random gap covers back-to-back and slow issue
  task automatic issue(input logic [15:0] iw, input logic [7:0] a, input logic [7:0] f, input logic c);
    repeat ($urandom_range(1, 0)) @(posedge clk);
    fetch.wr(12'h008, {15'h0000, c, f, a});
    fetch.wr(12'h004, {16'h0000, iw});
    @(posedge clk);
    #1;
  endtask
  initial begin
    rstn = 1'h0;
    void'($urandom(79));
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    #1;
    check("reset out", {hready, exec_nop, skip_request, alu_sel, flag_update}, 32'h400);
    check("hresp", hresp, 1'h0);
    fetch.rd(12'h000, rdv);
    check("ctrl", rdv, 32'h0000_0001);
    fetch.rd(12'h0FC, rdv);
    check("unmapped", rdv, 32'h0000_0000);
    for (int n = 0; n < 72; n++) begin
      k = n % 9;
      acc = 8'($urandom);
      fb = 8'($urandom);
      // every fourth pass forces the skip boundary
      if (n % 4 == 1) fb = (k == 4 || k == 5) ? 8'h01 : (k == 6 || k == 7) ? 8'hFF : acc;
      w = base[k] | {6'h00, (k > 3 || k == 0) & 1'($urandom), 1'($urandom), 8'($urandom)};
      ex = expect_of(k, acc, fb);
      issue(w, acc, fb, 1'($urandom));
      check("alu", alu_sel, ex[7:5]);
      check("flags", flag_update, ex[4:0]);
      check("skip", {exec_nop, skip_request}, ex[8]);
      check("bank", bank_select, w[8]);
      if (k == 0 || k > 3) check("dest", dest_to_file, w[9]);
      if (ex[8]) begin
        issue(base[0], acc, fb, 1'h0);
        check("skipped", {exec_nop, alu_sel}, 4'h8);
      end
    end
    cp = $urandom;
    issue({4'hC, cp[11:0]}, acc, fb, 1'h0);
    check("copy first", {exec_nop, alu_sel}, 4'h6);
    issue({4'hF, cp[23:12]}, acc, fb, 1'h0);
    check("copy second", exec_nop, 1'h1);
    fetch.rd(12'h010, rdv);
    check("copy reg", rdv, {7'h00, 1'h1, cp[23:0]});
    fetch.rd(12'h004, rdv);
    check("instr reg", rdv, {16'h0000, 4'hF, cp[23:12]});
    fetch.rd(12'h008, rdv);
    check("oper reg", rdv, {15'h0000, 1'h0, fb, acc});
    check("hresp okay", hresp, 1'h0);
    issue(16'hF123, acc, fb, 1'h0);
    check("lone second", {exec_nop, alu_sel}, 4'h8);
    issue(16'h2000, 8'h7F, 8'h80, 1'h1);
    fetch.rd(12'h00C, rdv);
    check("status", rdv, 32'h0027_003F);
    conclude();
  end
  // the tests need about 600 cycles; 20000 means a hang
  initial begin
    #2_000_000;
    error_cnt++;
    conclude();
  end
endmodule
